// ==== verilog/gph_pkg.sv ====
package gph_pkg;

    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [7:0] OFF_PIN_VALUE    = 8'h00;
    localparam logic [7:0] OFF_OUTPUT_LATCH = 8'h04;
    localparam logic [7:0] OFF_DIRECTION    = 8'h08;
    localparam logic [7:0] OFF_CONFIG       = 8'h0c;
    localparam logic [7:0] OFF_STATUS       = 8'h10;

    // ==========================================================
    // config register fields
    localparam int CFG_MEM_EN_BIT = 0;
    localparam int CFG_REMAP_BIT  = 1;
    localparam int CFG_ANA_LSB    = 4;
    localparam int CFG_ANA_W      = 4;

    // ==========================================================
    // reset values
    localparam logic [7:0] RST_LATCH     = 8'h00;
    localparam logic [7:0] RST_DIRECTION = 8'hff;
    localparam logic       RST_MEM_EN    = 1'h0;
    localparam logic       RST_REMAP     = 1'h1;
    localparam logic [3:0] RST_ANALOG    = 4'hf;

    // ==========================================================
    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    function automatic logic addr_mapped(input logic [7:0] a);
        logic hit;
        hit = 1'b0;
        if (a == OFF_PIN_VALUE) begin
            hit = 1'b1;
        end else if (a == OFF_OUTPUT_LATCH) begin
            hit = 1'b1;
        end else if (a == OFF_DIRECTION) begin
            hit = 1'b1;
        end else if (a == OFF_CONFIG) begin
            hit = 1'b1;
        end else if (a == OFF_STATUS) begin
            hit = 1'b1;
        end
        return hit;
    endfunction

endpackage

// ==== verilog/gph_pin_sync.sv ====
`timescale 1ns/1ns
module gph_pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    // ==========================================================
    // two-stage synchroniser, first stage read only by second
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync_out;

    initial begin
        if (WIDTH < 1) $error("gph_pin_sync: WIDTH must be at least 1");
    end

    always_comb begin
        next_stage1   = async_in;
        next_sync_out = stage1;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= next_stage1;
            sync_out <= next_sync_out;
        end
    end
endmodule

// ==== verilog/gph_axil_slave.sv ====
`timescale 1ns/1ns
module gph_axil_slave (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             wr_en,
    output logic [7:0]       wr_addr,
    output logic [7:0]       wr_data,
    output logic             wr_byte0,
    input  wire logic [7:0]  rd_word
);
    // ==========================================================
    // write path: address and data taken in either order
    logic       aw_held;
    logic       w_held;
    logic       next_aw_held;
    logic       next_w_held;
    logic [7:0] next_wr_addr;
    logic [7:0] next_wr_data;
    logic       next_wr_byte0;
    logic       next_bvalid;
    logic [1:0] next_bresp;

    // ==========================================================
    // read path: one cycle from address to data
    logic        next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;

    // ==========================================================
    // ready flags registered so every bus output leaves a flop
    logic        next_awready;
    logic        next_wready;
    logic        next_arready;

    always_comb begin
        wr_en         = aw_held && w_held && !s_axi_bvalid;
        next_aw_held  = aw_held;
        next_w_held   = w_held;
        next_wr_addr  = wr_addr;
        next_wr_data  = wr_data;
        next_wr_byte0 = wr_byte0;
        next_bvalid   = s_axi_bvalid;
        next_bresp    = s_axi_bresp;
        if (s_axi_awvalid && !aw_held) begin
            next_aw_held = 1'b1;
            next_wr_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held) begin
            next_w_held   = 1'b1;
            next_wr_data  = s_axi_wdata[7:0];
            next_wr_byte0 = s_axi_wstrb[0];
        end
        if (wr_en) begin
            next_bvalid = 1'b1;
            next_bresp  = gph_pkg::addr_mapped(wr_addr) ? gph_pkg::RESP_OKAY
                                                        : gph_pkg::RESP_SLVERR;
        end
        // held flags drop only once the answer is taken
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid  = 1'b0;
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
        end
        next_rvalid = s_axi_rvalid;
        next_rdata  = s_axi_rdata;
        next_rresp  = s_axi_rresp;
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && !s_axi_rvalid) begin
            next_rvalid = 1'b1;
            if (gph_pkg::addr_mapped(s_axi_araddr)) begin
                next_rdata = {24'h000000, rd_word};
                next_rresp = gph_pkg::RESP_OKAY;
            end else begin
                next_rdata = 32'h00000000;
                next_rresp = gph_pkg::RESP_SLVERR;
            end
        end
        // aw and w readies track the held flags one for one, arready tracks rvalid
        next_awready = !next_aw_held;
        next_wready  = !next_w_held;
        next_arready = !next_rvalid;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            wr_addr      <= 8'h00;
            wr_data      <= 8'h00;
            wr_byte0     <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= 2'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_arready <= 1'b1;
        end else begin
            aw_held      <= next_aw_held;
            w_held       <= next_w_held;
            wr_addr      <= next_wr_addr;
            wr_data      <= next_wr_data;
            wr_byte0     <= next_wr_byte0;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp  <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= next_rresp;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_arready <= next_arready;
        end
    end
endmodule

// ==== verilog/gph_port.sv ====
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ns
module gph_port #(
    parameter int PORT_W = 8
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [7:0]  pin_in,
    output logic [7:0]       pin_out,
    output logic [7:0]       pin_oe_n,
    input  wire logic        mem_addr_line_16,
    input  wire logic        mem_addr_line_17,
    input  wire logic        mem_addr_line_18,
    input  wire logic        mem_addr_line_19,
    input  wire logic        pwm_unit1_chan_b,
    input  wire logic        pwm_unit1_chan_c,
    input  wire logic        pwm_unit3_chan_b,
    input  wire logic        pwm_unit3_chan_c,
    input  wire logic [3:0]  pwm_shutdown_float,
    output logic             mem_if_enable,
    output logic             pwm_pin_remap_bit,
    output logic [3:0]       analog_channel_sel
);
    // ==========================================================
    // elaboration check
    initial begin
        if (PORT_W != 8) $error("gph_port: pin mux is built for 8 pins");
    end

    // ==========================================================
    // register state
    logic [7:0] port_output_latch;
    logic [7:0] port_direction;
    logic [3:0] analog_pin_config_field;
    logic [7:0] next_latch;
    logic [7:0] next_direction;
    logic       next_mem_en;
    logic       next_remap;
    logic [3:0] next_analog;

    // ==========================================================
    // bus slave hookup
    logic       wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic       wr_byte0;
    logic [7:0] rd_word;
    logic [7:0] pin_sync;
    logic [7:0] port_pin_value;

    gph_axil_slave u_bus (
        .clock         (clock),
        .rst           (rst),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_byte0      (wr_byte0),
        .rd_word       (rd_word)
    );

    // ==========================================================
    // pin input synchroniser
    // pins are asynchronous to the clock, so two stages first
    gph_pin_sync #(
        .WIDTH (8)
    ) u_sync (
        .clock    (clock),
        .rst      (rst),
        .async_in (pin_in),
        .sync_out (pin_sync)
    );

    // analog pins have their digital input cut, so they read as 0
    always_comb begin
        port_pin_value = pin_sync & ~{analog_pin_config_field, 4'h0};
    end

    // ==========================================================
    // register writes
    always_comb begin
        next_latch     = port_output_latch;
        next_direction = port_direction;
        next_mem_en    = mem_if_enable;
        next_remap     = pwm_pin_remap_bit;
        next_analog    = analog_pin_config_field;
        if (wr_en && wr_byte0) begin
            if (wr_addr == gph_pkg::OFF_PIN_VALUE) begin
                next_latch = wr_data;
            end else if (wr_addr == gph_pkg::OFF_OUTPUT_LATCH) begin
                next_latch = wr_data;
            end else if (wr_addr == gph_pkg::OFF_DIRECTION) begin
                next_direction = wr_data;
            end else if (wr_addr == gph_pkg::OFF_CONFIG) begin
                next_mem_en = wr_data[gph_pkg::CFG_MEM_EN_BIT];
                next_remap  = wr_data[gph_pkg::CFG_REMAP_BIT];
                next_analog = wr_data[gph_pkg::CFG_ANA_LSB +: gph_pkg::CFG_ANA_W];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            port_output_latch       <= gph_pkg::RST_LATCH;
            port_direction          <= gph_pkg::RST_DIRECTION;
            mem_if_enable           <= gph_pkg::RST_MEM_EN;
            pwm_pin_remap_bit       <= gph_pkg::RST_REMAP;
            analog_pin_config_field <= gph_pkg::RST_ANALOG;
        end else begin
            port_output_latch       <= next_latch;
            port_direction          <= next_direction;
            mem_if_enable           <= next_mem_en;
            pwm_pin_remap_bit       <= next_remap;
            analog_pin_config_field <= next_analog;
        end
    end

    // ==========================================================
    // register reads
    always_comb begin
        rd_word = 8'h00;
        if (s_axi_araddr == gph_pkg::OFF_PIN_VALUE) begin
            rd_word = port_pin_value;
        end else if (s_axi_araddr == gph_pkg::OFF_OUTPUT_LATCH) begin
            rd_word = port_output_latch;
        end else if (s_axi_araddr == gph_pkg::OFF_DIRECTION) begin
            rd_word = port_direction;
        end else if (s_axi_araddr == gph_pkg::OFF_CONFIG) begin
            rd_word[gph_pkg::CFG_MEM_EN_BIT] = mem_if_enable;
            rd_word[gph_pkg::CFG_REMAP_BIT]  = pwm_pin_remap_bit;
            rd_word[gph_pkg::CFG_ANA_LSB +: gph_pkg::CFG_ANA_W] = analog_pin_config_field;
        end else if (s_axi_araddr == gph_pkg::OFF_STATUS) begin
            rd_word = ~pin_oe_n;
        end
    end

    // ==========================================================
    // pin multiplexer
    logic [3:0] mem_addr_hi;
    logic [3:0] pwm_vec;
    logic [7:0] next_pin_out;
    logic [7:0] next_oe_n;
    logic [3:0] next_analog_sel;

    always_comb begin
        mem_addr_hi = {mem_addr_line_19, mem_addr_line_18,
                       mem_addr_line_17, mem_addr_line_16};
        // pin 4..7 order: unit3 C, unit3 B, unit1 C, unit1 B
        pwm_vec = {pwm_unit1_chan_b, pwm_unit1_chan_c,
                   pwm_unit3_chan_b, pwm_unit3_chan_c};
        for (int i = 0; i < 8; i++) begin
            // plain io unless a function claims the pin
            next_pin_out[i] = port_output_latch[i];
            next_oe_n[i]    = port_direction[i];
        end
        for (int i = 0; i < 4; i++) begin
            if (mem_if_enable) begin
                next_pin_out[i] = mem_addr_hi[i];
                next_oe_n[i]    = 1'b0;
            end
        end
        for (int j = 0; j < 4; j++) begin
            // remap set sends pwm elsewhere; pins stay port or analog
            if (!pwm_pin_remap_bit && !port_direction[j+4]) begin
                next_pin_out[j+4] = pwm_vec[j];
                next_oe_n[j+4]    = pwm_shutdown_float[j];
            end
        end
        // analog selection steers the converter and masks the pin value read, never the driver
        next_analog_sel = analog_pin_config_field;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pin_out            <= 8'h00;
            pin_oe_n           <= 8'hff;
            analog_channel_sel <= gph_pkg::RST_ANALOG;
        end else begin
            pin_out            <= next_pin_out;
            pin_oe_n           <= next_oe_n;
            analog_channel_sel <= next_analog_sel;
        end
    end
endmodule

// ==== dv/gph_board.sv ====
`timescale 1ns/1ns
// ==========================================================
// board side of the port pins
module gph_board (
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe_n,
    input  wire logic [7:0] board_val,
    output logic      [7:0] pin_in
);
    // board drives only pins the device floats, so no contention
    assign pin_in = (pin_oe_n & board_val) | (~pin_oe_n & pin_out);
endmodule

// ==== dv/gph_port_sva.sv ====
`timescale 1ns/1ns
module gph_port_sva #(
    parameter int PORT_W = 8
) (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [7:0]  pin_out,
    input wire logic [7:0]  pin_oe_n,
    input wire logic        mem_addr_line_16,
    input wire logic        mem_addr_line_17,
    input wire logic        mem_addr_line_18,
    input wire logic        mem_addr_line_19,
    input wire logic        pwm_unit1_chan_b,
    input wire logic        pwm_unit1_chan_c,
    input wire logic        pwm_unit3_chan_b,
    input wire logic        pwm_unit3_chan_c,
    input wire logic [3:0]  pwm_shutdown_float,
    input wire logic        mem_if_enable,
    input wire logic        pwm_pin_remap_bit,
    input wire logic [3:0]  analog_channel_sel
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // ==========================================================
    // pin multiplexing
    chk_mem_addr_out: assert property (mem_if_enable |=>
        pin_out[3:0] == $past({mem_addr_line_19, mem_addr_line_18,
        mem_addr_line_17, mem_addr_line_16}) && pin_oe_n[3:0] == 4'h0)
        else $error("address lines not on low pins");
    chk_pwm_out: assert property (!pwm_pin_remap_bit |=>
        ((pin_out[7:4] ^ $past({pwm_unit1_chan_b, pwm_unit1_chan_c,
        pwm_unit3_chan_b, pwm_unit3_chan_c})) & ~pin_oe_n[7:4]) == 4'h0)
        else $error("pwm level wrong on high pin");
    chk_pwm_float: assert property (!pwm_pin_remap_bit |=>
        (pin_oe_n[7:4] & $past(pwm_shutdown_float)) == $past(pwm_shutdown_float))
        else $error("shutdown pin still driven");
    chk_reset_state: assert property (disable iff (1'b0) rst |=>
        pin_oe_n == 8'hff && analog_channel_sel == 4'hf && !mem_if_enable)
        else $error("pin state after reset wrong");
    chk_analog_path: assert property ($changed(analog_channel_sel)
        && pwm_pin_remap_bit && !mem_if_enable && $stable(mem_if_enable)
        |=> $stable(pin_oe_n) [*2] ##0 $stable(pin_out))
        else $error("analog select moved the driver");
    // ==========================================================
    // register bus
    chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while busy");
    chk_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    cov_mem: cover property (mem_if_enable ##1 mem_if_enable);
    cov_pwm: cover property (!pwm_pin_remap_bit && pin_oe_n[7:4] == 4'h0);
    cov_float: cover property (!pwm_pin_remap_bit && pwm_shutdown_float != 4'h0);
endmodule

bind gph_port gph_port_sva #(.PORT_W(PORT_W)) u_sva (
    .clock(clock), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .mem_addr_line_16(mem_addr_line_16), .mem_addr_line_17(mem_addr_line_17),
    .mem_addr_line_18(mem_addr_line_18), .mem_addr_line_19(mem_addr_line_19),
    .pwm_unit1_chan_b(pwm_unit1_chan_b), .pwm_unit1_chan_c(pwm_unit1_chan_c),
    .pwm_unit3_chan_b(pwm_unit3_chan_b), .pwm_unit3_chan_c(pwm_unit3_chan_c),
    .pwm_shutdown_float(pwm_shutdown_float), .mem_if_enable(mem_if_enable),
    .pwm_pin_remap_bit(pwm_pin_remap_bit), .analog_channel_sel(analog_channel_sel));

// ==== dv/gph_port_bench.sv ====
`timescale 1ns/1ns
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
    $display("ERROR %0t got %h want %h", $time, a, e); end end
module gph_port_bench;
    localparam logic [7:0] A_PV  = gph_pkg::OFF_PIN_VALUE;
    localparam logic [7:0] A_LAT = gph_pkg::OFF_OUTPUT_LATCH;
    localparam logic [7:0] A_DIR = gph_pkg::OFF_DIRECTION;
    localparam logic [7:0] A_CFG = gph_pkg::OFF_CONFIG;
    localparam logic [1:0] OK    = gph_pkg::RESP_OKAY;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  awaddr = '0, araddr = '0, board = 8'hc3;
    logic [31:0] wdata = '0, rdata;
    logic [3:0]  wstrb = '0, mem = '0, pwm = '0, flt = '0, ana;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, mem_en, remap;
    logic [1:0]  bresp, rresp;
    logic [7:0]  pin_in, pin_out, pin_oe_n;
    int          err_count = 0;
    int          cmp_count = 0;

    always #10 clock = ~clock;

    gph_port #(.PORT_W(8)) uut (.clock(clock), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .mem_addr_line_16(mem[0]),
        .mem_addr_line_17(mem[1]), .mem_addr_line_18(mem[2]), .mem_addr_line_19(mem[3]),
        .pwm_unit1_chan_b(pwm[3]), .pwm_unit1_chan_c(pwm[2]), .pwm_unit3_chan_b(pwm[1]),
        .pwm_unit3_chan_c(pwm[0]), .pwm_shutdown_float(flt), .mem_if_enable(mem_en),
        .pwm_pin_remap_bit(remap), .analog_channel_sel(ana));

    gph_board u_board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .board_val(board),
        .pin_in(pin_in));

    // ==========================================================
    // closing and bus helpers
    task automatic complete_run();
        if (err_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic tmo(input int n);
        if (n >= 40) begin
            err_count++;
            complete_run();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d,
        input logic [1:0] er = gph_pkg::RESP_OKAY);
        int n;
        @(posedge clock);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'h1;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 40);
        bready <= 1'b0;
        tmo(n);
        `CHK(bresp, er)
    endtask

    // rready is raised late on purpose so read data must stand
    task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
        int n;
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 40);
        tmo(n);
        rready <= 1'b1;
        @(posedge clock);
        rready <= 1'b0;
        `CHK(rdata, {24'h0, ed})
        `CHK(rresp, er)
    endtask

    // pins lag a register by a cycle, pin reads by two more
    task automatic settle();
        repeat (4) @(posedge clock);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset();
        `CHK(pin_oe_n, 8'hff)
        `CHK(ana, 4'hf)
        // unmapped write must be refused and change nothing
        wr(8'h20, 8'hff, gph_pkg::RESP_SLVERR);
        rd(A_LAT, gph_pkg::RST_LATCH, OK);
        rd(A_DIR, 8'hff, OK);
        rd(A_CFG, 8'hf2, OK);
        rd(8'h20, 8'h00, gph_pkg::RESP_SLVERR);
    endtask

    task automatic t_gpio();
        wr(A_CFG, 8'h02);
        wr(A_PV, 8'ha5);
        wr(A_DIR, 8'h5a);
        settle();
        `CHK(pin_oe_n, 8'h5a)
        `CHK(pin_out & ~pin_oe_n, 8'ha5)
        rd(A_PV, 8'he7, OK);
        rd(A_LAT, 8'ha5, OK);
        rd(gph_pkg::OFF_STATUS, 8'ha5, OK);
    endtask

    task automatic t_mem();
        mem <= 4'ha;
        wr(A_CFG, 8'h03);
        wr(A_DIR, 8'hff);
        settle();
        `CHK(pin_out[3:0], 4'ha)
        `CHK(pin_oe_n, 8'hf0)
        `CHK(mem_en, 1'b1)
        mem <= 4'h3;
        settle();
        `CHK(pin_out[3:0], 4'h3)
        wr(A_CFG, 8'h02);
        settle();
        `CHK(pin_oe_n, 8'hff)
    endtask

    task automatic t_pwm();
        pwm <= 4'h9;
        wr(A_CFG, 8'h00);
        wr(A_DIR, 8'h0f);
        settle();
        `CHK(pin_out[7:4], 4'h9)
        `CHK(pin_oe_n, 8'h0f)
        `CHK(remap, 1'b0)
        flt <= 4'h5;
        pwm <= 4'h6;
        settle();
        `CHK(pin_oe_n[7:4], 4'h5)
        `CHK({pin_out[7], pin_out[5]}, 2'b01)
        wr(A_DIR, 8'hff);
        settle();
        `CHK(pin_oe_n[7:4], 4'hf)
        flt <= 4'h0;
        wr(A_CFG, 8'h02);
        wr(A_DIR, 8'h0f);
        settle();
        `CHK(pin_out[7:4], 4'ha)
        `CHK(pin_oe_n[7:4], 4'h0)
        `CHK(remap, 1'b1)
    endtask

    task automatic t_analog();
        wr(A_CFG, 8'hf2);
        settle();
        `CHK(ana, 4'hf)
        `CHK(pin_out[7:4], 4'ha)
        `CHK(pin_oe_n, 8'h0f)
        rd(A_PV, 8'h03, OK);
    endtask

    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_reset();
        t_gpio();
        t_mem();
        t_pwm();
        t_analog();
        // second reset in mid-run must restore every register
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_reset();
        complete_run();
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        complete_run();
    end
endmodule
